// ---- logic/nmi_integrity.sv ----
// Contract
// - each parameter has primary or secondary class
// - transfer policy: any alarm shuts down; code drops antenna alarms unless vswr_primary is set
// - best availability: only primary alarms shut down
// - nominal, pre-alarm and alarm limits per parameter
// - azimuth limits separate per monitor, others common
// - grade normal, pre-alarm or alarm by limits
// - test cycle every two minutes, both monitors
// - drive generator target, then compare sampled result
// - targets one tenth of span around limits
// - missed outside-limit alarm declares parameter alarm
// - false inside-limit alarm declares integrity alert
// - three consecutive misses remove monitor, raise alert
// - one passing cycle readmits removed monitor
// - excluded monitor shows integrity test failed
// - cycle unfinished in ten minutes removes monitor
// - bypass on/off from processor or control unit
// - antenna count over threshold shuts down after delay; code does so only with vswr_primary set, in either policy
/*
 monitor pair integrity supervisor: grading, shutdown policy and the
 periodic integrity sequencer. assumes monitor samples are stable when
 sample_valid pulses and the generator settles before sampling.
*/
module nmi_integrity
	import nmi_pkg::*;
#(
	parameter int SEC_CYC = nmi_pkg::NMI_SEC_CYC
)
(
	input wire logic clk, // 25 MHz clock
	input wire logic sys_rst, // synchronous reset, high
	input wire logic [nmi_pkg::NMI_NPAR-1:0] par_primary, // class per param
	input wire logic policy_best, // 1 best availability
	input wire logic [nmi_pkg::NMI_NPAR*nmi_pkg::NMI_W-1:0] nom_flat, // nominals
	input wire logic [nmi_pkg::NMI_NPAR*nmi_pkg::NMI_W-1:0] pre_lo_flat, // pre lo
	input wire logic [nmi_pkg::NMI_NPAR*nmi_pkg::NMI_W-1:0] pre_hi_flat, // pre hi
	input wire logic [nmi_pkg::NMI_NPAR*nmi_pkg::NMI_W-1:0] alm_lo_flat, // alm lo
	input wire logic [nmi_pkg::NMI_NPAR*nmi_pkg::NMI_W-1:0] alm_hi_flat, // alm hi
	input wire logic [4*nmi_pkg::NMI_W-1:0] az2_lims, // mon2 az prelo,prehi,lo,hi
	input wire logic [2*nmi_pkg::NMI_NPAR*nmi_pkg::NMI_W-1:0] meas_flat, // m2,m1
	input wire logic [1:0] sample_valid, // per monitor sample strobe
	input wire logic [1:0] mon_alarm, // monitor alarm during test
	input wire logic [1:0] byp_maint, // bypass from maintenance_processor
	input wire logic [1:0] byp_local_control_unit, // bypass from control unit
	input wire logic [15:0] shutdown_delay_s, // shutdown delay, seconds
	input wire logic vswr_primary, // antenna mismatch classed primary
	input wire logic [3:0] vswr_ant_alarm, // antennas in alarm
	input wire logic [3:0] vswr_thresh, // antennas threshold
	output logic [2*2*nmi_pkg::NMI_NPAR-1:0] grade_flat, // grades m2,m1
	output logic shutdown, // system shutdown
	output logic [nmi_pkg::NMI_W-1:0] gen_target, // generator target
	output logic gen_valid, // generator target applied
	output logic [2:0] gen_param, // parameter under test
	output logic [1:0] gen_case, // 0 lolo 1 lohi 2 hilo 3 hihi
	output logic [2*nmi_pkg::NMI_NPAR-1:0] itest_alarm, // missed alarm
	output logic [2*nmi_pkg::NMI_NPAR-1:0] itest_alert, // false alarm
	output logic [1:0] voting_en, // monitor admitted to voting
	output logic [1:0] integ_failed, // integrity test failed flag
	output logic [1:0] maint_alert // monitor maintenance alert
);
	localparam int NP = NMI_NPAR;
	localparam int W = NMI_W;

	logic [1:0] bypass_r;
	logic [26:0] div_r;
	logic sec_tick;
	logic [2*2*NP-1:0] grade_nxt;
	logic [31:0] delay_r;
	logic sd_cause;
	logic [1:0] prim_act, sec_act;

	// bypass: a pulse from either source toggles it; pulses from both at once set it
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			bypass_r <= 2'h0;
		else
			bypass_r <= (bypass_r | (byp_maint & byp_local_control_unit))
				^ (byp_maint ^ byp_local_control_unit);
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst || div_r == 27'(SEC_CYC - 1))
			div_r <= '0;
		else
			div_r <= div_r + 27'h1;
	end
	assign sec_tick = (div_r == 27'(SEC_CYC - 1));

	genvar m, p;
	generate
		for (m = 0; m < 2; m++)
		begin : g_mon
			for (p = 0; p < NP; p++)
			begin : g_par
				logic signed [W-1:0] v, plo, phi, alo, ahi;
				assign v = meas_flat[(m*NP+p)*W +: W];
				// monitor 2 azimuth has its own limit set
				assign plo = (m == 1 && p == NMI_AZ_IDX) ? az2_lims[0 +: W]
					: pre_lo_flat[p*W +: W];
				assign phi = (m == 1 && p == NMI_AZ_IDX) ? az2_lims[W +: W]
					: pre_hi_flat[p*W +: W];
				assign alo = (m == 1 && p == NMI_AZ_IDX) ? az2_lims[2*W +: W]
					: alm_lo_flat[p*W +: W];
				assign ahi = (m == 1 && p == NMI_AZ_IDX) ? az2_lims[3*W +: W]
					: alm_hi_flat[p*W +: W];
				assign grade_nxt[(m*NP+p)*2 +: 2] =
					(v < alo || v > ahi) ? NMI_G_ALARM :
					(v < plo || v > phi) ? NMI_G_PRE : NMI_G_NORMAL;
			end
			assign prim_act[m] = !bypass_r[m] && |(par_primary & {
				grade_nxt[(m*NP+7)*2+1], grade_nxt[(m*NP+6)*2+1],
				grade_nxt[(m*NP+5)*2+1], grade_nxt[(m*NP+4)*2+1],
				grade_nxt[(m*NP+3)*2+1], grade_nxt[(m*NP+2)*2+1],
				grade_nxt[(m*NP+1)*2+1], grade_nxt[(m*NP)*2+1]});
			assign sec_act[m] = !bypass_r[m] && |(~par_primary & {
				grade_nxt[(m*NP+7)*2+1], grade_nxt[(m*NP+6)*2+1],
				grade_nxt[(m*NP+5)*2+1], grade_nxt[(m*NP+4)*2+1],
				grade_nxt[(m*NP+3)*2+1], grade_nxt[(m*NP+2)*2+1],
				grade_nxt[(m*NP+1)*2+1], grade_nxt[(m*NP)*2+1]});
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			grade_flat <= '0;
		else
			grade_flat <= grade_nxt; // bypassed monitors still graded
	end

	// shutdown cause per transfer policy
	assign sd_cause = |prim_act
		|| (policy_best == NMI_POL_TRANSFER && |sec_act)
		|| (vswr_primary && vswr_ant_alarm > vswr_thresh);

	// delay counts seconds of continuous cause; restarts when it clears
	always_ff @(posedge clk)
	begin
		if (sys_rst || !sd_cause)
			delay_r <= '0;
		else if (sec_tick && delay_r < {16'h0000, shutdown_delay_s})
			delay_r <= delay_r + 32'h1;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			shutdown <= 1'b0;
		else
			shutdown <= sd_cause && delay_r >= {16'h0000, shutdown_delay_s};
	end

	// integrity sequencer, both monitors tested per case together
	nmi_state_e st_r;
	logic [11:0] cyc_sec_r;
	logic [2:0] par_r;
	logic [1:0] case_r;
	logic [1:0] got_r;
	logic [1:0] miss_in_cycle_r, fail_in_cycle_r;
	logic [1:0] mon_alm_r;
	logic [1:0][1:0] miss_cnt_r;
	logic [1:0][11:0] overdue_r;
	logic signed [W-1:0] t_lo, t_hi, t_nom, span, tgt;
	logic outside_case;

	assign t_nom = nom_flat[par_r*W +: W];
	assign t_lo = alm_lo_flat[par_r*W +: W];
	assign t_hi = alm_hi_flat[par_r*W +: W];
	assign span = case_r[1] ? (t_hi - t_nom) / W'(NMI_DIV)
		: (t_nom - t_lo) / W'(NMI_DIV);
	assign tgt = case_r[1] ? (case_r[0] ? t_hi + span : t_hi - span)
		: (case_r[0] ? t_lo + span : t_lo - span);
	assign outside_case = (case_r == 2'h0) || (case_r == 2'h3);

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			st_r <= NMI_IDLE;
			cyc_sec_r <= '0;
			par_r <= '0;
			case_r <= '0;
			got_r <= '0;
			mon_alm_r <= '0;
			gen_valid <= 1'b0;
			gen_target <= '0;
		end
		else
		begin
			if (sec_tick && cyc_sec_r != 12'(NMI_CYCLE_SEC - 1))
				cyc_sec_r <= cyc_sec_r + 12'h1;
			case (st_r)
			NMI_IDLE:
				if (sec_tick && cyc_sec_r == 12'(NMI_CYCLE_SEC - 1))
				begin
					cyc_sec_r <= '0;
					par_r <= '0;
					case_r <= '0;
					st_r <= NMI_SET;
				end
			NMI_SET:
			begin
				gen_target <= tgt;
				gen_valid <= 1'b1;
				got_r <= '0;
				st_r <= NMI_WAIT;
			end
			NMI_WAIT:
			begin
				got_r <= got_r | sample_valid;
				mon_alm_r <= (mon_alm_r & got_r) | (mon_alarm & sample_valid);
				if ((got_r | sample_valid) == 2'h3)
					st_r <= NMI_JUDGE;
			end
			NMI_JUDGE:
			begin
				gen_valid <= 1'b0;
				st_r <= NMI_NEXT;
			end
			NMI_NEXT:
			begin
				case_r <= case_r + 2'h1;
				if (case_r == 2'h3)
					par_r <= par_r + 3'h1;
				st_r <= (case_r == 2'h3 && par_r == 3'(NP - 1))
					? NMI_IDLE : NMI_SET;
			end
			default:
				st_r <= NMI_IDLE;
			endcase
		end
	end

	assign gen_param = par_r;
	assign gen_case = case_r;

	genvar k;
	generate
		for (k = 0; k < 2; k++)
		begin : g_res
			logic miss, false_alm;
			// per-monitor result bits keep each process on its own variable
			logic [NP-1:0] alm_r, alt_r;
			assign itest_alarm[k*NP +: NP] = alm_r;
			assign itest_alert[k*NP +: NP] = alt_r;
			assign miss = st_r == NMI_JUDGE && outside_case && !mon_alm_r[k];
			assign false_alm = st_r == NMI_JUDGE && !outside_case
				&& mon_alm_r[k];
			always_ff @(posedge clk)
			begin
				if (sys_rst)
				begin
					alm_r <= '0;
					alt_r <= '0;
				end
				else if (st_r == NMI_JUDGE)
				begin
					if (case_r == 2'h0)
					begin
						alm_r[par_r] <= miss;
						alt_r[par_r] <= false_alm;
					end
					else
					begin
						if (miss)
							alm_r[par_r] <= 1'b1;
						if (false_alm)
							alt_r[par_r] <= 1'b1;
					end
				end
			end
			always_ff @(posedge clk)
			begin
				if (sys_rst)
				begin
					miss_in_cycle_r[k] <= 1'b0;
					fail_in_cycle_r[k] <= 1'b0;
					miss_cnt_r[k] <= '0;
					overdue_r[k] <= '0;
					voting_en[k] <= 1'b1;
					integ_failed[k] <= 1'b0;
					maint_alert[k] <= 1'b0;
				end
				else
				begin
					if (miss)
						miss_in_cycle_r[k] <= 1'b1;
					if (miss || false_alm)
						fail_in_cycle_r[k] <= 1'b1;
					if (sec_tick && overdue_r[k] != 12'(NMI_OVERDUE_SEC))
						overdue_r[k] <= overdue_r[k] + 12'h1;
					if (st_r == NMI_NEXT && case_r == 2'h3
						&& par_r == 3'(NP - 1))
					begin
						miss_in_cycle_r[k] <= 1'b0;
						fail_in_cycle_r[k] <= 1'b0;
						overdue_r[k] <= '0;
						if (miss_in_cycle_r[k])
						begin
							if (miss_cnt_r[k] != 2'(NMI_MISS_LIMIT))
								miss_cnt_r[k] <= miss_cnt_r[k] + 2'h1;
							if (miss_cnt_r[k] >= 2'(NMI_MISS_LIMIT - 1))
							begin
								voting_en[k] <= 1'b0;
								integ_failed[k] <= 1'b1;
								maint_alert[k] <= 1'b1;
							end
						end
						else
							miss_cnt_r[k] <= '0;
						if (!fail_in_cycle_r[k] && !miss_in_cycle_r[k])
						begin
							voting_en[k] <= 1'b1;
							integ_failed[k] <= 1'b0;
							maint_alert[k] <= 1'b0;
						end
					end
					else if (overdue_r[k] == 12'(NMI_OVERDUE_SEC))
					begin
						voting_en[k] <= 1'b0;
						integ_failed[k] <= 1'b1;
					end
				end
			end

			a_readmit_pass: assert property (@(posedge clk) disable iff (sys_rst)
				(st_r == NMI_NEXT && case_r == 2'h3 && par_r == 3'(NP - 1)
				&& !fail_in_cycle_r[k] && !miss_in_cycle_r[k])
				|=> voting_en[k])
				else $error("monitor not readmitted after passing cycle");
			a_excl_flag: assert property (@(posedge clk) disable iff (sys_rst)
				!voting_en[k] |-> integ_failed[k])
				else $error("excluded monitor without failed flag");
			a_miss_flag: assert property (@(posedge clk) disable iff (sys_rst)
				miss |=> alm_r[$past(par_r)])
				else $error("missed alarm not declared");
		end
	endgenerate

	a_best_sec: assert property (@(posedge clk) disable iff (sys_rst)
		(policy_best && !(|prim_act) && !(vswr_primary
		&& vswr_ant_alarm > vswr_thresh)) |=> !shutdown)
		else $error("shutdown on secondary alarm only");
	a_delay_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!sd_cause |=> !shutdown)
		else $error("shutdown without active cause");
	a_case_order: assert property (@(posedge clk) disable iff (sys_rst)
		st_r == NMI_SET |=> st_r == NMI_WAIT && gen_valid)
		else $error("target not applied before sampling");
	a_byp_excl: assert property (@(posedge clk) disable iff (sys_rst)
		bypass_r[0] |-> !prim_act[0])
		else $error("bypassed monitor drives shutdown");
	a_period_idle: assert property (@(posedge clk) disable iff (sys_rst)
		(st_r == NMI_SET && $past(st_r) == NMI_IDLE) |-> cyc_sec_r == 12'h0)
		else $error("test cycle period counter not kept");
endmodule

// ---- logic/nmi_pkg.sv ----
/*
 package for the monitor integrity supervisor: parameter count, value
 width, grading codes, transfer policies and time base constants.
 assumes a single 25 MHz clock.
*/
package nmi_pkg;
	localparam int NMI_NPAR = 8;
	localparam int NMI_W = 16;
	localparam int NMI_AZ_IDX = 0;
	localparam int NMI_CLK_HZ = 25000000;
	localparam int NMI_SEC_CYC = NMI_CLK_HZ;
	localparam int NMI_CYCLE_MIN = 2;
	localparam int NMI_CYCLE_SEC = NMI_CYCLE_MIN * 60;
	localparam int NMI_OVERDUE_MIN = 10;
	localparam int NMI_OVERDUE_SEC = NMI_OVERDUE_MIN * 60;
	localparam int NMI_MISS_LIMIT = 3;
	localparam int NMI_DIV = 10;
	localparam logic [1:0] NMI_G_NORMAL = 2'h0;
	localparam logic [1:0] NMI_G_PRE = 2'h1;
	localparam logic [1:0] NMI_G_ALARM = 2'h2;
	localparam logic NMI_POL_TRANSFER = 1'b0;
	localparam logic NMI_POL_BEST = 1'b1;
	typedef enum logic [2:0] {
		NMI_IDLE, NMI_SET, NMI_WAIT, NMI_JUDGE, NMI_NEXT
	} nmi_state_e;
endpackage

// ---- verification/nmi_mon_model.sv ----
/*
 monitor pair model: answers each generator target with one sample
 strobe and an alarm verdict against the common alarm limits.
 assumes gen_valid holds until the strobe has been taken.
*/
module nmi_mon_model
	import nmi_pkg::*;
#(
	parameter int DLY = 3
)
(
	input wire logic clk, // clock
	input wire logic sys_rst, // sync reset
	input wire logic gen_valid, // target applied
	input wire logic [15:0] gen_target, // generator level
	input wire logic [2:0] gen_param, // parameter under test
	input wire logic [127:0] alm_lo_flat, // low alarm limits
	input wire logic [127:0] alm_hi_flat, // high alarm limits
	input wire logic [1:0] miss, // fault: alarm never raised
	input wire logic [1:0] false_alm, // fault: alarm always raised
	input wire logic stall, // fault: never samples
	output logic [1:0] sample_valid, // sample strobe
	output logic [1:0] mon_alarm // alarm verdict
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt;
	logic lo_out;
	logic hi_out;
	assign lo_out = $signed(gen_target) < $signed(alm_lo_flat[gen_param*16+:16]);
	assign hi_out = $signed(gen_target) > $signed(alm_hi_flat[gen_param*16+:16]);
	always_ff @(posedge clk)
	begin
		sample_valid <= 2'b00;
		// idle verdict flips so a stale value is never trusted
		mon_alarm <= ~mon_alarm;
		if (sys_rst || !gen_valid)
			cnt <= 0;
		else if (!stall && cnt <= DLY)
			cnt <= cnt + 1;
		if (sys_rst)
			mon_alarm <= 2'b00;
		else if (gen_valid && !stall && cnt == DLY)
		begin
			sample_valid <= 2'b11;
			mon_alarm <= false_alm | ({2{lo_out | hi_out}} & ~miss);
		end
	end
endmodule

// ---- verification/test_navaid_monitor_integrity.sv ----
/*
 testbench for nmi_integrity: grading, shutdown policy and the
 integrity sequencer. assumes SEC_CYC of 10, one second = 10 clocks.
*/
module test_navaid_monitor_integrity
	import nmi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, sys_rst = 1, policy_best = 1, vswr_primary = 0, stall = 0;
	logic [7:0] par_primary = 0;
	logic [127:0] nom_flat = {8{16'h03e8}}, pre_lo_flat = {8{16'h0384}};
	logic [127:0] pre_hi_flat = {8{16'h044c}}, alm_lo_flat = {8{16'h0320}};
	logic [127:0] alm_hi_flat = {8{16'h04b0}};
	logic [63:0] az2_lims = {16'h05dc, 16'h02bc, 16'h0578, 16'h02ee};
	logic [255:0] meas_flat = {16{16'h03e8}};
	logic [1:0] byp_maint = 0, byp_local_control_unit = 0, miss = 0;
	logic [1:0] false_alm = 0, sample_valid, mon_alarm, gen_case;
	logic [1:0] voting_en, integ_failed, maint_alert;
	logic [15:0] shutdown_delay_s = 16'h0003, gen_target, itest_alarm, itest_alert;
	logic [3:0] vswr_ant_alarm = 0, vswr_thresh = 4'h2;
	logic [31:0] grade_flat;
	logic [2:0] gen_param;
	logic shutdown, gen_valid;
	int miscompares = 0, n_checks = 0;
	longint t0;
	always #20 clk = ~clk;
	nmi_integrity #(.SEC_CYC(10)) i_nmi_integrity (.clk, .sys_rst,
		.par_primary, .policy_best, .nom_flat, .pre_lo_flat, .pre_hi_flat,
		.alm_lo_flat, .alm_hi_flat, .az2_lims, .meas_flat, .sample_valid,
		.mon_alarm, .byp_maint, .byp_local_control_unit, .shutdown_delay_s,
		.vswr_primary, .vswr_ant_alarm, .vswr_thresh, .grade_flat, .shutdown,
		.gen_target, .gen_valid, .gen_param, .gen_case, .itest_alarm,
		.itest_alert, .voting_en, .integ_failed, .maint_alert);
	nmi_mon_model i_nmi_mon_model (.clk, .sys_rst, .gen_valid, .gen_target,
		.gen_param, .alm_lo_flat, .alm_hi_flat, .miss, .false_alm, .stall,
		.sample_valid, .mon_alarm);
	task summarize;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task wait_case(input logic [2:0] p, input logic [1:0] c);
		for (int k = 0; k < 3000 && !(gen_valid === 1'b1 && gen_param === p
			&& gen_case === c); k++)
			step(1);
	endtask
	task cyc_end;
		wait_case(3'h7, 2'h3);
		step(10);
	endtask
	initial
	begin
		#1000000;
		miscompares++;
		summarize;
	end
	initial
	begin
		step(6);
		sys_rst = 0;
		chk({shutdown, voting_en, integ_failed, maint_alert, gen_valid}, 8'h60);
		meas_flat[0+:16] = 16'h047e;
		meas_flat[128+:16] = 16'h047e;
		meas_flat[16+:16] = 16'h0352;
		meas_flat[32+:16] = 16'h04e2;
		meas_flat[176+:16] = 16'h0302;
		step(40);
		chk(grade_flat, 32'h0080_0025);
		chk(shutdown, 0);
		az2_lims = {16'h04b0, 16'h0320, 16'h044c, 16'h0384};
		meas_flat = {16{16'h03e8}};
		policy_best = 0;
		step(5);
		meas_flat[32+:16] = 16'h04e2;
		step(15);
		meas_flat[32+:16] = 16'h03e8;
		step(2);
		meas_flat[32+:16] = 16'h04e2;
		step(18);
		chk(shutdown, 0);
		step(27);
		chk(shutdown, 1);
		meas_flat[32+:16] = 16'h03e8;
		policy_best = 1;
		par_primary = 8'h04;
		step(5);
		chk(shutdown, 0);
		meas_flat[32+:16] = 16'h04e2;
		step(45);
		chk(shutdown, 1);
		byp_maint = 2'b01;
		step(1);
		byp_maint = 0;
		step(5);
		chk(shutdown, 0);
		chk(grade_flat[5:4], 2'h2);
		byp_local_control_unit = 2'b01;
		step(1);
		byp_local_control_unit = 0;
		step(45);
		chk(shutdown, 1);
		meas_flat[32+:16] = 16'h03e8;
		vswr_primary = 1;
		vswr_ant_alarm = 4'h2;
		step(45);
		chk(shutdown, 0);
		vswr_ant_alarm = 4'h3;
		step(45);
		chk(shutdown, 1);
		vswr_ant_alarm = 0;
		wait_case(3'h0, 2'h0);
		t0 = $time;
		chk(gen_target, 16'h030c);
		wait_case(3'h0, 2'h3);
		chk(gen_target, 16'h04c4);
		cyc_end;
		chk({itest_alarm, itest_alert, voting_en}, 34'h3);
		miss = 2'b10;
		wait_case(3'h0, 2'h0);
		chk(32'(($time - t0) / 40), 32'h0000_04b0);
		cyc_end;
		chk({itest_alarm, voting_en}, {16'hff00, 2'b11});
		cyc_end;
		cyc_end;
		chk({voting_en, integ_failed, maint_alert}, 6'h1a);
		miss = 0;
		cyc_end;
		chk({voting_en, integ_failed, itest_alarm}, {4'hc, 16'h0});
		false_alm = 2'b01;
		cyc_end;
		chk({itest_alert, itest_alarm, voting_en}, {32'h00ff_0000, 2'b11});
		false_alm = 0;
		stall = 1;
		step(5850);
		chk(voting_en, 2'b11);
		step(300);
		chk(voting_en, 2'b00);
		summarize;
	end
endmodule
